// file: sit_pkg.sv
// Shared constants and types for the sensor I2C target port.
// Assumes a 20 MHz system clock and a separate link sampling clock.
package sit_pkg;
  // Strapped target addresses
  localparam logic [6:0] ADDR_STRAP_LOW = 7'h18;
  localparam logic [6:0] ADDR_STRAP_HIGH = 7'h19;
  // Link sampling clock and fastest serial clock
  localparam int LINK_PERIOD_NS = 80;
  localparam int SCL_MAX_KHZ = 1000;
  localparam int OVERSAMPLE = 1000000 / (SCL_MAX_KHZ * LINK_PERIOD_NS);
  // Lockup timer periods
  localparam int WDT_SHORT_US = 1250;
  localparam int WDT_LONG_US = 40000;
  localparam int WDT_SHORT_CYC = WDT_SHORT_US * 1000 / LINK_PERIOD_NS;
  localparam int WDT_LONG_CYC = WDT_LONG_US * 1000 / LINK_PERIOD_NS;
  localparam int WDT_W = 19;
  // Byte framing
  localparam logic [3:0] BIT_FULL = 4'h8;
  localparam logic [2:0] TX_LAST = 3'h7;
  localparam logic [1:0] BYTE_DEV = 2'h0;
  localparam logic [1:0] BYTE_REG = 2'h1;
  localparam logic [1:0] BYTE_DATA = 2'h2;
  localparam logic [7:0] REG_RESET_ADDR = 8'h00;
  localparam logic [7:0] TRAP_ADDR_DEF = 8'h26;
  // Command word: {is_write, address, data}
  localparam int CMD_W = 17;
  localparam int CMD_WR_BIT = 16;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b011,
    ST_TX = 3'b010,
    ST_MACK = 3'b110
  } sit_state_e;
endpackage : sit_pkg

// file: sit_hs_cross.sv
// Toggle handshake that carries one word between two clock domains.
// Assumes the source holds off while busy; data is stable until acked.
`timescale 1ns/10ps
module sit_hs_cross #(
  parameter int W = 8
) (
  // Source side
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic src_send,
  input wire logic [W-1:0] src_data,
  output logic src_busy,
  // Destination side
  input wire logic dst_clk,
  input wire logic dst_rst,
  output logic dst_pulse,
  output logic [W-1:0] dst_data
);
  logic req_reg, req_next;
  logic [W-1:0] hold_reg, hold_next;
  logic ack_s1_reg, ack_s2_reg;
  logic req_s1_reg, req_s2_reg, req_s3_reg;
  logic pulse_reg, pulse_next;
  logic [W-1:0] data_reg, data_next;

  assign src_busy = req_reg ^ ack_s2_reg;

  always_comb begin
    req_next = req_reg;
    hold_next = hold_reg;
    if (src_send && !src_busy) begin
      req_next = ~req_reg;
      hold_next = src_data;
    end
  end

  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      req_reg <= 1'b0;
      hold_reg <= '0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      req_reg <= req_next;
      hold_reg <= hold_next;
      ack_s1_reg <= req_s3_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  // Held word is only sampled once the toggle has settled
  always_comb begin
    pulse_next = req_s2_reg ^ req_s3_reg;
    data_next = pulse_next ? hold_reg : data_reg;
  end

  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
      pulse_reg <= 1'b0;
      data_reg <= '0;
    end else begin
      req_s1_reg <= req_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      pulse_reg <= pulse_next;
      data_reg <= data_next;
    end
  end

  assign dst_pulse = pulse_reg;
  assign dst_data = data_reg;
endmodule : sit_hs_cross

// file: sit_i2c_target.sv
// I2C target port: oversampled engine on the link clock, register
// access strobes on the system clock. Assumes external pull-ups and a
// register file that answers a read strobe one clk cycle later.
`timescale 1ns/10ps
// Function
// - Answer 0x18 strap low, 0x19 strap high
// - Standard and fast modes, 7-bit addresses only
// - Extended mode accepts clocks up to 1 MHz
// - Start condition marks the bus busy
// - Detect stop and end the transfer
// - Acknowledge held low through clock high
// - Write: address, RW zero, register byte acked
// - Data byte acked, then stored at register
// - Advance address, except trapped special register
// - Read: repeated start, controller ack/nack, stop
// - Reads start at last written register address
// - Lockup timer resets interface when bus stuck
module sit_i2c_target import sit_pkg::*; #(
  parameter int WDT_SHORT = WDT_SHORT_CYC,
  parameter int WDT_LONG = WDT_LONG_CYC,
  parameter logic [7:0] TRAP_ADDR = TRAP_ADDR_DEF
) (
  // System clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link sampling clock
  input wire logic link_clk,
  // Bus pins
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  input wire logic address_select_pin,
  // Lockup timer configuration
  input wire logic lockup_timer_enable,
  input wire logic lockup_timer_period_select,
  // Register file access
  output logic reg_wr_pulse,
  output logic reg_rd_pulse,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data
);
  // Link-domain synchronisers
  logic rst_s1_reg, link_rst;
  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic strap_s1_reg, strap_s2_reg;
  logic en_s1_reg, en_s2_reg, sel_s1_reg, sel_s2_reg;

  // Samples at 80 ns give about a dozen per 1 MHz bit
  always_ff @(posedge link_clk) begin
    rst_s1_reg <= sys_rst;
    link_rst <= rst_s1_reg;
    scl_s1_reg <= serial_clock_pin_in;
    scl_s2_reg <= scl_s1_reg;
    scl_d_reg <= scl_s2_reg;
    sda_s1_reg <= serial_data_pin_in;
    sda_s2_reg <= sda_s1_reg;
    sda_d_reg <= sda_s2_reg;
    strap_s1_reg <= address_select_pin;
    strap_s2_reg <= strap_s1_reg;
    en_s1_reg <= lockup_timer_enable;
    en_s2_reg <= en_s1_reg;
    sel_s1_reg <= lockup_timer_period_select;
    sel_s2_reg <= sel_s1_reg;
  end

  logic scl_rise, scl_fall, start_det, stop_det, stop_ok;
  assign scl_rise = scl_s2_reg && !scl_d_reg;
  assign scl_fall = !scl_s2_reg && scl_d_reg;
  assign start_det = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg;
  assign stop_det = scl_s2_reg && scl_d_reg && !sda_d_reg && sda_s2_reg;

  // Engine state
  sit_state_e state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [1:0] byte_cnt_reg, byte_cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] ptr_reg, ptr_next, base_reg, base_next;
  logic [6:0] my_addr_reg, my_addr_next;
  logic strap_done_reg, strap_done_next;
  logic rw_reg, rw_next, sda_oe_reg, sda_oe_next;
  logic scl_oe_reg, scl_oe_next, rd_valid_reg, rd_valid_next;
  logic seen_low_reg, seen_low_next;
  logic [WDT_W-1:0] wdt_cnt_reg, wdt_cnt_next, wdt_limit;
  logic cmd_send_reg, cmd_send_next;
  logic [CMD_W-1:0] cmd_word_reg, cmd_word_next;
  logic wdt_trip, byte_done, wr_accept, rd_open;
  logic rsp_pulse;
  logic [7:0] rsp_data;

  // A stop right after a start, with no clock low, is not seen
  assign stop_ok = stop_det && (state_reg == ST_IDLE || seen_low_reg);
  assign wdt_limit = sel_s2_reg ? WDT_W'(WDT_LONG) : WDT_W'(WDT_SHORT);
  assign wdt_trip = en_s2_reg && wdt_cnt_reg >= wdt_limit;
  assign byte_done = !wdt_trip && !start_det && !stop_ok
    && state_reg == ST_RX && scl_fall && bit_cnt_reg == BIT_FULL;

  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    byte_cnt_next = byte_cnt_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    base_next = base_reg;
    my_addr_next = my_addr_reg;
    strap_done_next = 1'b1;
    rw_next = rw_reg;
    sda_oe_next = sda_oe_reg;
    scl_oe_next = scl_oe_reg;
    rd_valid_next = rd_valid_reg || rsp_pulse;
    seen_low_next = seen_low_reg || scl_fall;
    cmd_send_next = 1'b0;
    cmd_word_next = cmd_word_reg;
    wr_accept = 1'b0;
    rd_open = 1'b0;
    // Timer only runs while this end pulls a line and nothing moves
    if (scl_rise || scl_fall || !(sda_oe_reg || scl_oe_reg))
      wdt_cnt_next = '0;
    else
      wdt_cnt_next = wdt_cnt_reg + WDT_W'(1);
    if (!strap_done_reg)
      my_addr_next = strap_s2_reg ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW;
    if (wdt_trip) begin
      state_next = ST_IDLE;
      sda_oe_next = 1'b0;
      scl_oe_next = 1'b0;
    end else if (start_det) begin
      state_next = ST_RX;
      bit_cnt_next = '0;
      byte_cnt_next = BYTE_DEV;
      sda_oe_next = 1'b0;
      scl_oe_next = 1'b0;
      rd_valid_next = 1'b0;
      seen_low_next = 1'b0;
    end else if (stop_ok) begin
      state_next = ST_IDLE;
      sda_oe_next = 1'b0;
      scl_oe_next = 1'b0;
    end else begin
      case (state_reg)
        ST_RX: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], sda_s2_reg};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            bit_cnt_next = '0;
            state_next = ST_ACK;
            sda_oe_next = 1'b1;
            case (byte_cnt_reg)
              BYTE_DEV: begin
                // 10-bit headers never match a 7-bit address
                if (sh_reg[7:1] == my_addr_reg) begin
                  rw_next = sh_reg[0];
                  if (sh_reg[0]) begin
                    rd_open = 1'b1;
                    ptr_next = base_reg;
                    rd_valid_next = 1'b0;
                    cmd_send_next = 1'b1;
                    cmd_word_next = {1'b0, base_reg, REG_RESET_ADDR};
                  end
                end else begin
                  state_next = ST_IDLE;
                  sda_oe_next = 1'b0;
                end
              end
              BYTE_REG: begin
                ptr_next = sh_reg;
                base_next = sh_reg;
              end
              default: begin
                wr_accept = 1'b1;
                cmd_send_next = 1'b1;
                cmd_word_next = {1'b1, ptr_reg, sh_reg};
                if (ptr_reg != TRAP_ADDR)
                  ptr_next = ptr_reg + 8'h01;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall || scl_oe_reg) begin
            if (!rw_reg) begin
              sda_oe_next = 1'b0;
              state_next = ST_RX;
              if (byte_cnt_reg != BYTE_DATA)
                byte_cnt_next = byte_cnt_reg + 2'h1;
            end else if (rd_valid_reg) begin
              // Stretch released once the byte has crossed over
              sh_next = rsp_data;
              sda_oe_next = !rsp_data[7];
              scl_oe_next = 1'b0;
              rd_valid_next = 1'b0;
              bit_cnt_next = '0;
              state_next = ST_TX;
              if (ptr_reg != TRAP_ADDR)
                ptr_next = ptr_reg + 8'h01;
            end else begin
              sda_oe_next = 1'b0;
              scl_oe_next = 1'b1;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg[2:0] == TX_LAST) begin
              sda_oe_next = 1'b0;
              bit_cnt_next = '0;
              state_next = ST_MACK;
            end else begin
              sh_next = {sh_reg[6:0], 1'b0};
              sda_oe_next = !sh_reg[6];
              bit_cnt_next = bit_cnt_reg + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            if (!sda_s2_reg) begin
              bit_cnt_next = 4'h1;
              cmd_send_next = 1'b1;
              cmd_word_next = {1'b0, ptr_reg, REG_RESET_ADDR};
            end else begin
              state_next = ST_IDLE;
            end
          end else if (scl_fall && bit_cnt_reg != 4'h0) begin
            bit_cnt_next = '0;
            state_next = ST_ACK;
            scl_oe_next = 1'b1;
          end
        end
        ST_IDLE: ;
        default: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= '0;
      byte_cnt_reg <= BYTE_DEV;
      sh_reg <= '0;
      ptr_reg <= REG_RESET_ADDR;
      base_reg <= REG_RESET_ADDR;
      my_addr_reg <= ADDR_STRAP_LOW;
      strap_done_reg <= 1'b0;
      rw_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      rd_valid_reg <= 1'b0;
      seen_low_reg <= 1'b0;
      wdt_cnt_reg <= '0;
      cmd_send_reg <= 1'b0;
      cmd_word_reg <= '0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      byte_cnt_reg <= byte_cnt_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      base_reg <= base_next;
      my_addr_reg <= my_addr_next;
      strap_done_reg <= strap_done_next;
      rw_reg <= rw_next;
      sda_oe_reg <= sda_oe_next;
      scl_oe_reg <= scl_oe_next;
      rd_valid_reg <= rd_valid_next;
      seen_low_reg <= seen_low_next;
      wdt_cnt_reg <= wdt_cnt_next;
      cmd_send_reg <= cmd_send_next;
      cmd_word_reg <= cmd_word_next;
    end
  end

  // Open-drain pins only ever pull low
  assign serial_clock_pin_out = 1'b0;
  assign serial_clock_pin_oe = scl_oe_reg;
  assign serial_data_pin_out = 1'b0;
  assign serial_data_pin_oe = sda_oe_reg;

  // Crossings
  logic cmd_pulse;
  logic [CMD_W-1:0] cmd_data;
  logic rsp_send_reg, rsp_send_next;

  sit_hs_cross #(.W(CMD_W)) u_cmd (
    .src_clk(link_clk),
    .src_rst(link_rst),
    .src_send(cmd_send_reg),
    .src_data(cmd_word_reg),
    .src_busy(),
    .dst_clk(clk),
    .dst_rst(sys_rst),
    .dst_pulse(cmd_pulse),
    .dst_data(cmd_data)
  );

  sit_hs_cross #(.W(8)) u_rsp (
    .src_clk(clk),
    .src_rst(sys_rst),
    .src_send(rsp_send_reg),
    .src_data(reg_rd_data),
    .src_busy(),
    .dst_clk(link_clk),
    .dst_rst(link_rst),
    .dst_pulse(rsp_pulse),
    .dst_data(rsp_data)
  );

  // System-side strobes
  logic wr_pulse_reg, wr_pulse_next, rd_pulse_reg, rd_pulse_next;
  logic [7:0] addr_reg, addr_next, wdata_reg, wdata_next;

  always_comb begin
    wr_pulse_next = cmd_pulse && cmd_data[CMD_WR_BIT];
    rd_pulse_next = cmd_pulse && !cmd_data[CMD_WR_BIT];
    addr_next = cmd_pulse ? cmd_data[15:8] : addr_reg;
    wdata_next = wr_pulse_next ? cmd_data[7:0] : wdata_reg;
    rsp_send_next = rd_pulse_reg;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pulse_reg <= 1'b0;
      rd_pulse_reg <= 1'b0;
      addr_reg <= REG_RESET_ADDR;
      wdata_reg <= '0;
      rsp_send_reg <= 1'b0;
    end else begin
      wr_pulse_reg <= wr_pulse_next;
      rd_pulse_reg <= rd_pulse_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rsp_send_reg <= rsp_send_next;
    end
  end

  assign reg_wr_pulse = wr_pulse_reg;
  assign reg_rd_pulse = rd_pulse_reg;
  assign reg_addr = addr_reg;
  assign reg_wr_data = wdata_reg;

  // Checks
  nack_foreign_a: assert property (@(posedge link_clk)
    disable iff (link_rst) byte_done && byte_cnt_reg == BYTE_DEV
    && sh_reg[7:1] != my_addr_reg |=> (!sda_oe_reg)[*2])
    else $error("foreign address acknowledged");
  ack_own_a: assert property (@(posedge link_clk)
    disable iff (link_rst) byte_done && byte_cnt_reg == BYTE_DEV
    && sh_reg[7:1] == my_addr_reg |=> sda_oe_reg && state_reg == ST_ACK)
    else $error("own address not acknowledged");
  start_busy_a: assert property (@(posedge link_clk)
    disable iff (link_rst) start_det && !wdt_trip
    |=> state_reg == ST_RX && bit_cnt_reg == 4'h0)
    else $error("start not taken");
  stop_idle_a: assert property (@(posedge link_clk)
    disable iff (link_rst) stop_ok && !wdt_trip && !start_det
    |=> state_reg == ST_IDLE && !sda_oe_reg)
    else $error("stop not taken");
  ack_hold_a: assert property (@(posedge link_clk)
    disable iff (link_rst) state_reg == ST_ACK && sda_oe_reg
    && scl_s2_reg && !wdt_trip |=> sda_oe_reg)
    else $error("acknowledge dropped during clock high");
  bare_stop_a: assert property (@(posedge link_clk)
    disable iff (link_rst) stop_det && state_reg == ST_RX
    && !seen_low_reg && !wdt_trip |=> state_reg != ST_IDLE)
    else $error("stop after bare start accepted");
  addr_step_a: assert property (@(posedge link_clk)
    disable iff (link_rst) wr_accept && ptr_reg != TRAP_ADDR
    |=> ptr_reg == $past(ptr_reg) + 8'h01 ##1 cmd_send_reg == 1'b0)
    else $error("write address not advanced");
  addr_trap_a: assert property (@(posedge link_clk)
    disable iff (link_rst) wr_accept && ptr_reg == TRAP_ADDR
    |=> ptr_reg == TRAP_ADDR && cmd_word_reg[15:8] == TRAP_ADDR)
    else $error("trapped address moved");
  read_base_a: assert property (@(posedge link_clk)
    disable iff (link_rst) rd_open
    |=> ptr_reg == base_reg && cmd_send_reg && !cmd_word_reg[CMD_WR_BIT])
    else $error("read not started at last written address");
  lockup_free_a: assert property (@(posedge link_clk)
    disable iff (link_rst) wdt_trip
    |=> !sda_oe_reg && !scl_oe_reg && state_reg == ST_IDLE)
    else $error("lockup timer did not release the bus");
  wr_strobe_a: assert property (@(posedge clk)
    disable iff (sys_rst) cmd_pulse && cmd_data[CMD_WR_BIT]
    |=> reg_wr_pulse && reg_wr_data == $past(cmd_data[7:0]) ##1 !reg_wr_pulse)
    else $error("write strobe malformed");
endmodule : sit_i2c_target

// file: sit_ctrl_model.sv
// Behavioural I2C bus controller for the target port bench.
// Assumes pull-ups in the bench: a released wire reads high.
`timescale 1ns/10ps
module sit_ctrl_model (
  // Pull-downs, high = pull the wire low
  output logic ctrl_scl_pull,
  output logic ctrl_sda_pull,
  // Resolved wire levels
  input wire logic scl_wire,
  input wire logic sda_wire
);
  // Half clock period; 500 gives 1 MHz, larger values run slowly
  int half_ns = 500;
  // Set while the device sits in a low-power mode
  bit low_power = 1'b0;

  initial begin
    ctrl_scl_pull = 1'b0;
    ctrl_sda_pull = 1'b0;
  end

  // Data moves 100 ns after the fall so the target never sees a false
  // start or stop; the stretch wait is bounded so a hang cannot stall it
  task automatic clk_bit(input logic b, output logic r);
    #100;
    ctrl_sda_pull = !b;
    #(half_ns - 100);
    ctrl_scl_pull = 1'b0;
    for (int i = 0; i < 4000 && scl_wire !== 1'b1; i++) #10;
    #(half_ns);
    r = sda_wire;
    ctrl_scl_pull = 1'b1;
  endtask : clk_bit

  // Serves as repeated start as well
  task automatic start();
    #100;
    ctrl_sda_pull = 1'b0;
    #(half_ns);
    ctrl_scl_pull = 1'b0;
    #(half_ns);
    ctrl_sda_pull = 1'b1;
    #(half_ns);
    ctrl_scl_pull = 1'b1;
  endtask : start

  // Only ever follows clocked bits, never a bare start
  task automatic stop();
    #100;
    ctrl_sda_pull = 1'b1;
    #(half_ns);
    ctrl_scl_pull = 1'b0;
    #(half_ns);
    ctrl_sda_pull = 1'b0;
    #(half_ns);
    // Writes must settle inside the device before the next access
    if (low_power) #1000us;
  endtask : stop

  task automatic send_bits(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
  endtask : send_bits

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    send_bits(d);
    clk_bit(1'b1, ack);
  endtask : wr_byte

  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(last, r);
  endtask : rd_byte
endmodule : sit_ctrl_model

// file: sit_i2c_target_tb.sv
// Self-checking bench for the I2C target port with a register file.
// Assumes the controller model and shortened lockup periods.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin comparisons++; \
  if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module sit_i2c_target_tb;
  import sit_pkg::*;
  logic clk = 0, link_clk = 0, sys_rst = 1, address_select_pin = 0;
  logic lockup_timer_enable = 0, lockup_timer_period_select = 0;
  logic serial_clock_pin_out, serial_clock_pin_oe;
  logic serial_data_pin_out, serial_data_pin_oe;
  logic reg_wr_pulse, reg_rd_pulse, a;
  logic [7:0] reg_addr, reg_wr_data, d, reg_rd_data = 8'h00;
  logic [7:0] mem [256];
  logic ctrl_scl_pull, ctrl_sda_pull, scl_wire, sda_wire;
  int n_fail = 0, comparisons = 0, wr_cnt = 0, cyc = 0;

  always #25 clk = ~clk;
  always #40 link_clk = ~link_clk;

  assign scl_wire = !(ctrl_scl_pull ||
                      (serial_clock_pin_oe && !serial_clock_pin_out));
  assign sda_wire = !(ctrl_sda_pull ||
                      (serial_data_pin_oe && !serial_data_pin_out));

  sit_i2c_target #(.WDT_SHORT(40), .WDT_LONG(80)) uut (
    .clk(clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .serial_clock_pin_in(scl_wire),
    .serial_clock_pin_out(serial_clock_pin_out),
    .serial_clock_pin_oe(serial_clock_pin_oe),
    .serial_data_pin_in(sda_wire),
    .serial_data_pin_out(serial_data_pin_out),
    .serial_data_pin_oe(serial_data_pin_oe),
    .address_select_pin(address_select_pin),
    .lockup_timer_enable(lockup_timer_enable),
    .lockup_timer_period_select(lockup_timer_period_select),
    .reg_wr_pulse(reg_wr_pulse), .reg_rd_pulse(reg_rd_pulse),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data)
  );

  sit_ctrl_model ctrl (
    .ctrl_scl_pull(ctrl_scl_pull), .ctrl_sda_pull(ctrl_sda_pull),
    .scl_wire(scl_wire), .sda_wire(sda_wire)
  );

  // Register file answers a read strobe on the following cycle
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  always @(posedge clk) begin
    // An unknown strobe counts as a write so it cannot slip through
    if (reg_wr_pulse !== 1'b0) wr_cnt <= wr_cnt + 1;
    if (reg_wr_pulse === 1'b1) mem[reg_addr] <= reg_wr_data;
    if (reg_rd_pulse === 1'b1) reg_rd_data <= mem[reg_addr];
  end

  // Whole run needs about 30000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      print_verdict();
    end
  end

  task print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  task send(input logic [7:0] b, input logic exp);
    ctrl.wr_byte(b, a);
    `CHK("ack", exp, a)
  endtask : send

  // Held 5 cycles; the link side still sees three of its own edges
  task reset_dut(input logic strap);
    @(posedge clk);
    #1 sys_rst = 1'b1;
    address_select_pin = strap;
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (20) @(posedge clk);
    `CHK("reg_addr", 8'h00, reg_addr)
  endtask : reset_dut

  task t_read_reset();
    ctrl.start();
    send(8'h31, 1'b0);
    ctrl.rd_byte(1'b1, d);
    `CHK("rd reset", 8'h5a, d)
    ctrl.stop();
  endtask : t_read_reset

  task t_lockup(input logic sel);
    @(posedge clk);
    #1 lockup_timer_enable = 1'b1;
    lockup_timer_period_select = sel;
    repeat (10) @(posedge clk);
    ctrl.start();
    ctrl.send_bits(8'h30);
    #800;
    `CHK("ack held", 1'b1, serial_data_pin_oe)
    #4000;
    `CHK("lockup", sel, serial_data_pin_oe)
    #4000;
    `CHK("lockup late", 1'b0, serial_data_pin_oe)
    ctrl.stop();
    @(posedge clk);
    #1 lockup_timer_enable = 1'b0;
  endtask : t_lockup

  task t_write();
    ctrl.start();
    send(8'h30, 1'b0);
    send(8'h41, 1'b0);
    send(8'h01, 1'b0);
    send(8'h02, 1'b0);
    ctrl.stop();
    repeat (20) @(posedge clk);
    `CHK("wr 41", 8'h01, mem[8'h41])
    `CHK("wr 42", 8'h02, mem[8'h42])
  endtask : t_write

  task t_slow_trap();
    ctrl.half_ns = 2500;
    ctrl.low_power = 1'b1;
    ctrl.start();
    send(8'h30, 1'b0);
    send(TRAP_ADDR_DEF, 1'b0);
    send(8'ha5, 1'b0);
    send(8'h3c, 1'b0);
    ctrl.stop();
    ctrl.half_ns = 500;
    ctrl.low_power = 1'b0;
    repeat (20) @(posedge clk);
    `CHK("trap", 8'h3c, mem[TRAP_ADDR_DEF])
    `CHK("after trap", 8'h7d, mem[TRAP_ADDR_DEF + 8'h01])
  endtask : t_slow_trap

  task t_read();
    ctrl.start();
    send(8'h30, 1'b0);
    send(8'h10, 1'b0);
    ctrl.start();
    send(8'h31, 1'b0);
    for (int i = 0; i < 3; i++) begin
      ctrl.rd_byte(i == 2, d);
      `CHK("rd seq", 8'(8'h10 + i) ^ 8'h5a, d)
    end
    ctrl.stop();
  endtask : t_read

  task t_read_again();
    ctrl.start();
    send(8'h31, 1'b0);
    ctrl.rd_byte(1'b1, d);
    `CHK("rd again", 8'h4a, d)
    ctrl.stop();
  endtask : t_read_again

  task t_mismatch();
    int n;
    n = wr_cnt;
    ctrl.start();
    send(8'h33, 1'b1);
    ctrl.stop();
    ctrl.start();
    send(8'hf0, 1'b1);
    ctrl.stop();
    ctrl.start();
    send(8'h32, 1'b1);
    send(8'h44, 1'b1);
    ctrl.stop();
    repeat (20) @(posedge clk);
    `CHK("no write", n, wr_cnt)
  endtask : t_mismatch

  task t_strap_high();
    reset_dut(1'b1);
    ctrl.start();
    send(8'h32, 1'b0);
    send(8'h50, 1'b0);
    send(8'h77, 1'b0);
    ctrl.stop();
    ctrl.start();
    send(8'h30, 1'b1);
    ctrl.stop();
    repeat (20) @(posedge clk);
    `CHK("strap high", 8'h77, mem[8'h50])
  endtask : t_strap_high

  initial begin
    reset_dut(1'b0);
    t_read_reset();
    t_lockup(1'b0);
    t_lockup(1'b1);
    t_write();
    t_slow_trap();
    t_read();
    t_read_again();
    t_mismatch();
    t_strap_high();
    print_verdict();
  end
endmodule : sit_i2c_target_tb
